// ===== core/rdi2c_regs.vh
// rdi2c_regs.vh : constants of the redriver management target
`ifndef RDI2C_REGS_VH
`define RDI2C_REGS_VH

// register offsets
`define RDI2C_GEN_CTRL_OFS   8'he2
`define RDI2C_IDENT_LOW_OFS  8'hf0
`define RDI2C_IDENT_HIGH_OFS 8'hf1

// general control fields and reset value
`define RDI2C_GC_SOFT_RST_BIT 6
`define RDI2C_GC_EE_LOAD_BIT  0
`define RDI2C_GC_WR_MASK      8'h41
`define RDI2C_GC_RESET        8'h00

// identification low register layout
`define RDI2C_ID_LOW_FIXED    8'h10
`define RDI2C_ID_LOW_CODE_LSB 1

// address construction from strap levels
`define RDI2C_ADDR_BASE       7'h18
`define RDI2C_ADDR_HIGH_STEP  7'h08
`define RDI2C_ADDR_LOW_STEP   7'h02

// five-level strap codes
`define RDI2C_LVL_L2          3'h2
`define RDI2C_LVL_L3          3'h3
`define RDI2C_MODE_TARGET     3'h2

// bit count of one bus byte
`define RDI2C_BYTE_BITS       4'h8
`define RDI2C_READ_NACK       1'h1

`endif

// ===== core/rdi2c_addr_decode.v
// rdi2c_addr_decode.v : strap capture and target address match
`default_nettype none
`include "rdi2c_regs.vh"

module rdi2c_addr_decode (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_n_in,
  // straps, three-bit level code per pin, bank order A15-8 A7-0 B15-8 B7-0
  input  wire [11:0] strap_high_in,
  input  wire [11:0] strap_low_in,
  input  wire [2:0]  mode_strap_in,
  // received address and match result
  input  wire [6:0]  rx_addr_in,
  output reg         hit_out,
  output reg  [2:0]  group_out,
  output reg         target_en_out
);

  reg        cap_done_q;
  reg [11:0] high_q;
  reg [11:0] low_q;
  reg        hit_d;
  reg [2:0]  group_d;
  reg [6:0]  even_d;
  integer    b;

  // even address of one bank, the odd one is this plus one
  function [6:0] bank_addr;
    input [2:0] hi;
    input [2:0] lo;
    begin
      bank_addr = `RDI2C_ADDR_BASE + hi[1:0] * `RDI2C_ADDR_HIGH_STEP +
                  lo[1:0] * `RDI2C_ADDR_LOW_STEP;
    end
  endfunction

  // straps taken once after reset release and never again
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_done_q    <= 1'b0;
      high_q        <= 12'h000;
      low_q         <= 12'h000;
      target_en_out <= 1'b0;
    end else if (!cap_done_q) begin
      cap_done_q    <= 1'b1;
      high_q        <= strap_high_in;
      low_q         <= strap_low_in;
      target_en_out <= (mode_strap_in == `RDI2C_MODE_TARGET);
    end
  end

  // match; banks whose straps sit at L4 have no address at all
  always @* begin
    hit_d   = 1'b0;
    group_d = 3'h0;
    even_d  = 7'h00;
    for (b = 3; b >= 0; b = b - 1) begin
      // bit 0 of the even address is always zero, so compare the rest
      even_d = bank_addr(high_q[b*3 +: 3], low_q[b*3 +: 3]);
      if (cap_done_q && high_q[b*3 +: 3] <= `RDI2C_LVL_L3 &&
          low_q[b*3 +: 3] <= `RDI2C_LVL_L3 &&
          rx_addr_in[6:1] == even_d[6:1]) begin
        hit_d   = 1'b1;
        group_d = {b[1:0], rx_addr_in[0]};
      end
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hit_out   <= 1'b0;
      group_out <= 3'h0;
    end else begin
      hit_out   <= hit_d;
      group_out <= group_d;
    end
  end

endmodule // rdi2c_addr_decode
`default_nettype wire

// ===== core/rdi2c_target.v
// rdi2c_target.v : bus target with shared control and identification
`default_nettype none
`include "rdi2c_regs.vh"

// Operation
// - even address 0x18 plus 8*high plus 2*low
// - odd address is even address plus one
// - bit 6 resets all registers, self-clears
// - bit 0 forces EEPROM load unless bit 6 is also set, self-clears
// - ident low: code bits 3-1, bit 4 one
// - ident high: read-only eight-bit device code
// - target active only when mode strap L2
// - straps sampled once after each reset release
// - each strap pair addresses one lane bank
module rdi2c_target #(
  parameter [2:0] IDENT_LOW_CODE  = 3'h5,  // arbitrary value
  parameter [7:0] IDENT_HIGH_CODE = 8'h5a  // arbitrary value
) (
  // clock and reset
  input  wire        mclk_in,
  input  wire        nrst_in,
  // straps, three-bit level code per pin
  input  wire [11:0] strap_high_in,
  input  wire [11:0] strap_low_in,
  input  wire [2:0]  mode_strap_in,
  // bus pins, data open drain
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_out,
  // effects on the rest of the device
  output reg         regs_reset_out,
  output reg         eeprom_load_out,
  output reg  [2:0]  lane_group_out
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACKA = 7'h04;
  localparam [6:0] ST_WDAT = 7'h08;
  localparam [6:0] ST_ACKW = 7'h10;
  localparam [6:0] ST_RDAT = 7'h20;
  localparam [6:0] ST_ACKR = 7'h40;

  reg  [1:0] rst_sync_q;
  wire       rst_n;
  reg        scl_q;
  reg        sda_q;
  reg  [6:0] state_q;
  reg  [3:0] cnt_q;
  reg  [7:0] sr_q;
  reg  [7:0] tx_q;
  reg  [7:0] ptr_q;
  reg        have_ptr_q;
  reg        rw_q;
  reg        nack_q;
  reg  [7:0] gc_q;
  wire [7:0] rd_data;
  wire       hit;
  wire [2:0] group;
  wire       target_en;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;

  // read view of the shared registers; other offsets read zero
  function [7:0] reg_read;
    input [7:0] ofs;
    input [7:0] gc;
    begin
      if (ofs == `RDI2C_GEN_CTRL_OFS) begin
        reg_read = gc;
      end else if (ofs == `RDI2C_IDENT_LOW_OFS) begin
        reg_read = `RDI2C_ID_LOW_FIXED |
                   {4'h0, IDENT_LOW_CODE, 1'b0};
      end else if (ofs == `RDI2C_IDENT_HIGH_OFS) begin
        reg_read = IDENT_HIGH_CODE;
      end else begin
        reg_read = 8'h00;
      end
    end
  endfunction

  // read view at the current offset, loaded into the shifter
  assign rd_data = reg_read(ptr_q, gc_q);

  // reset released through two flops
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  rdi2c_addr_decode u_addr (
    .clk_in        (mclk_in),
    .rst_n_in      (rst_n),
    .strap_high_in (strap_high_in),
    .strap_low_in  (strap_low_in),
    .mode_strap_in (mode_strap_in),
    .rx_addr_in    (sr_q[7:1]),
    .hit_out       (hit),
    .group_out     (group),
    .target_en_out (target_en)
  );

  // bus conditions from one-cycle-old pin samples
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;

  // bus protocol engine; data changes only while scl is low
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_q          <= 1'b1;
      sda_q          <= 1'b1;
      state_q        <= ST_IDLE;
      cnt_q          <= 4'h0;
      sr_q           <= 8'h00;
      tx_q           <= 8'h00;
      ptr_q          <= 8'h00;
      have_ptr_q     <= 1'b0;
      rw_q           <= 1'b0;
      nack_q         <= 1'b0;
      gc_q           <= `RDI2C_GC_RESET;
      sda_out        <= 1'b0;
      sda_oe_out     <= 1'b0;
      regs_reset_out <= 1'b0;
      eeprom_load_out<= 1'b0;
      lane_group_out <= 3'h0;
    end else begin
      scl_q           <= scl_in;
      sda_q           <= sda_in;
      regs_reset_out  <= 1'b0;
      eeprom_load_out <= 1'b0;
      // self-clearing actions take effect one cycle after the write
      if (gc_q[`RDI2C_GC_SOFT_RST_BIT]) begin
        gc_q           <= `RDI2C_GC_RESET;
        regs_reset_out <= 1'b1;
        ptr_q          <= 8'h00;
      end else if (gc_q[`RDI2C_GC_EE_LOAD_BIT]) begin
        gc_q[`RDI2C_GC_EE_LOAD_BIT] <= 1'b0;
        eeprom_load_out <= 1'b1;
      end
      if (start_cond) begin
        state_q    <= ST_ADDR;
        cnt_q      <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_cond) begin
        state_q    <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR: begin
            if (scl_rise) begin
              sr_q  <= {sr_q[6:0], sda_in};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `RDI2C_BYTE_BITS) begin
              // silent unless the bus mode strap was chosen
              if (hit && target_en) begin
                state_q        <= ST_ACKA;
                sda_oe_out     <= 1'b1;
                rw_q           <= sr_q[0];
                have_ptr_q     <= 1'b0;
                lane_group_out <= group;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ACKA: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                tx_q       <= rd_data;
                sda_oe_out <= ~rd_data[7];
                state_q    <= ST_RDAT;
              end else begin
                sda_oe_out <= 1'b0;
                state_q    <= ST_WDAT;
              end
            end
          end
          ST_WDAT: begin
            if (scl_rise) begin
              sr_q  <= {sr_q[6:0], sda_in};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `RDI2C_BYTE_BITS) begin
              // first byte selects the offset, later bytes write it
              if (!have_ptr_q) begin
                ptr_q      <= sr_q;
                have_ptr_q <= 1'b1;
              end else begin
                if (ptr_q == `RDI2C_GEN_CTRL_OFS) begin
                  gc_q <= sr_q & `RDI2C_GC_WR_MASK;
                end
                ptr_q <= ptr_q + 8'h01; // ident writes fall away
              end
              sda_oe_out <= 1'b1;
              state_q    <= ST_ACKW;
            end
          end
          ST_ACKW: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              cnt_q      <= 4'h0;
              state_q    <= ST_WDAT;
            end
          end
          ST_RDAT: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == `RDI2C_BYTE_BITS) begin
                sda_oe_out <= 1'b0;
                ptr_q      <= ptr_q + 8'h01;
                state_q    <= ST_ACKR;
              end else begin
                tx_q       <= {tx_q[6:0], 1'b0};
                sda_oe_out <= ~tx_q[6];
              end
            end
          end
          ST_ACKR: begin
            if (scl_rise) begin
              nack_q <= (sda_in == `RDI2C_READ_NACK);
            end else if (scl_fall) begin
              // a nack ends the read; the host then sends stop
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                cnt_q      <= 4'h0;
                tx_q       <= rd_data;
                sda_oe_out <= ~rd_data[7];
                state_q    <= ST_RDAT;
              end
            end
          end
          default: begin
            state_q    <= ST_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // rdi2c_target
`default_nettype wire

// ===== testbench/rdi2c_props.sv
// checker of the management bus target port behaviour
`default_nettype none
module rdi2c_props (
  // clock and reset
  input wire logic       mclk_in,
  input wire logic       nrst_in,
  // watched pins
  input wire logic [2:0] mode_strap_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_oe_out,
  input wire logic       regs_reset_out,
  input wire logic       eeprom_load_out,
  input wire logic [2:0] lane_group_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // effect pulses last one cycle and never meet
  rst_pulse_a: assert property (regs_reset_out |=> !regs_reset_out)
    else $error("soft reset pulse too long");
  ld_pulse_a: assert property (eeprom_load_out |=> !eeprom_load_out)
    else $error("load pulse too long");
  no_both_a: assert property (!(regs_reset_out && eeprom_load_out))
    else $error("load beside soft reset");
  // effects land with the bus clock low, the load also in the data ack
  rst_ack_a: assert property (regs_reset_out |-> !scl_in)
    else $error("soft reset with clock high");
  ld_ack_a: assert property (eeprom_load_out |-> sda_oe_out && !scl_in)
    else $error("load outside data ack");
  // data only moves while the bus clock is low
  oe_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data moved with clock high");
  mode_off_a: assert property (mode_strap_in != 3'h2 |-> !sda_oe_out)
    else $error("driven outside target mode");
  stop_rel_a: assert property (scl_in && $rose(sda_in) |=> !sda_oe_out)
    else $error("driving after stop");
  // lane group stays zero for three cycles after reset release
  rel_quiet_a: assert property ($rose(nrst_in) |->
    (lane_group_out == 3'h0)[*3]) else $error("group set at release");
  cover property (regs_reset_out);
  cover property (eeprom_load_out);
  cover property ($rose(sda_oe_out) && lane_group_out[2]);
endmodule // rdi2c_props
bind rdi2c_target rdi2c_props i_rdi2c_props (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .mode_strap_in(mode_strap_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_oe_out(sda_oe_out),
  .regs_reset_out(regs_reset_out), .eeprom_load_out(eeprom_load_out),
  .lane_group_out(lane_group_out));
`default_nettype wire

// ===== testbench/rdi2c_host.sv
// bus controller model for the management bus
`default_nettype none
module rdi2c_host (
  // clock
  input  wire logic clk_in,
  // bus, data released high
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_out <= 1'b1;
    cyc(3);
    scl_out <= 1'b1;
    cyc(4);
    sda_out <= 1'b0;
    cyc(4);
    scl_out <= 1'b0;
    cyc(3);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_out <= 1'b0;
    cyc(3);
    scl_out <= 1'b1;
    cyc(4);
    sda_out <= 1'b1;
    cyc(6);
  endtask
  // one bit, sampled mid high phase; high phase 4 clocks, low phase 6
  task automatic bitx(input logic b, output logic r);
    sda_out <= b;
    cyc(3);
    scl_out <= 1'b1;
    cyc(2);
    r = sda_in;
    cyc(2);
    scl_out <= 1'b0;
    cyc(3);
  endtask
  // byte msb first, then the ninth bit
  task automatic xb(input logic [7:0] d, input logic nb,
                    output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(nb, ak);
  endtask
endmodule // rdi2c_host
`default_nettype wire

// ===== testbench/test_redriver_i2c_target_shared_regs.sv
// self-checking bench of the management bus target
`default_nettype none
module test_redriver_i2c_target_shared_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] IDL = 3'h5;  // arbitrary value
  localparam logic [7:0] IDH = 8'h5a; // arbitrary value
  // banks 3..0: high L2 L1 L0 L3, low L1 L2 L0 L3, low kept off L4
  logic [11:0] sh = 12'h443;
  logic [11:0] sl = 12'h283;
  logic        mclk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [2:0]  mode = 3'h2;
  logic        scl, hsda, oe, rr, ld, sdo;
  logic [2:0]  grp;
  wire         sda = oe ? sdo : hsda; // host level unless the target drives
  int          error_cnt = 0;
  int          total_checks = 0;
  int          n_rr = 0;
  int          n_ld = 0;
  always #4 mclk_in = ~mclk_in;
  rdi2c_target #(.IDENT_LOW_CODE(IDL), .IDENT_HIGH_CODE(IDH)) i_rdi2c_target (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .strap_high_in(sh),
    .strap_low_in(sl), .mode_strap_in(mode), .scl_in(scl), .sda_in(sda),
    .sda_out(sdo), .sda_oe_out(oe), .regs_reset_out(rr),
    .eeprom_load_out(ld), .lane_group_out(grp));
  rdi2c_host h (.clk_in(mclk_in), .sda_in(sda), .scl_out(scl),
    .sda_out(hsda));
  // count one-cycle effect pulses
  always @(posedge mclk_in) begin
    if (rr === 1'b1) n_rr <= n_rr + 1;
    if (ld === 1'b1) n_ld <= n_ld + 1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic probe(input logic [6:0] a, output logic ok);
    logic [7:0] q;
    logic k;
    h.start();
    h.xb({a, 1'b0}, 1'b1, q, k);
    h.stop();
    ok = !k;
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] v);
    logic [7:0] q;
    logic k;
    h.start();
    h.xb(8'h30, 1'b1, q, k);
    h.xb(o, 1'b1, q, k);
    h.xb(v, 1'b1, q, k);
    h.stop();
  endtask
  // offset write, repeated start, one byte read ended by nack
  task automatic rd(input logic [7:0] o, output logic [7:0] v);
    logic [7:0] q;
    logic k;
    h.start();
    h.xb(8'h30, 1'b1, q, k);
    h.xb(o, 1'b1, q, k);
    h.start();
    h.xb(8'h31, 1'b1, q, k);
    h.xb(8'hff, 1'b1, v, k);
    h.stop();
  endtask
  task automatic t_addr();
    logic [6:0] a;
    logic ok;
    for (int b = 0; b < 4; b++)
      for (int d = 0; d < 2; d++) begin
        a = 7'h18 + {sh[3*b+:3], 3'h0} + {sl[3*b+:3], 1'b0} + 7'(d);
        probe(a, ok);
        chk({7'h00, ok}, 8'h01);
        chk({5'h00, grp}, {5'h00, 2'(b), 1'(d)});
      end
    sh <= 12'h000;
    probe(7'h37, ok);
    chk({7'h00, ok}, 8'h01);
    probe(7'h50, ok);
    chk({7'h00, ok}, 8'h00);
  endtask
  task automatic t_ident();
    logic [7:0] v;
    logic [7:0] q;
    logic       k;
    rd(8'hf0, v);
    chk(v, 8'h10 | {4'h0, IDL, 1'b0});
    wr(8'hf1, 8'h00);
    rd(8'hf1, v);
    chk(v, IDH);
    // two-byte read acked in between, offset steps on by itself
    h.start();
    h.xb(8'h30, 1'b1, q, k);
    h.xb(8'hf0, 1'b1, q, k);
    h.start();
    h.xb(8'h31, 1'b1, q, k);
    h.xb(8'hff, 1'b0, v, k);
    chk(v, 8'h10 | {4'h0, IDL, 1'b0});
    h.xb(8'hff, 1'b1, v, k);
    h.stop();
    chk(v, IDH);
  endtask
  task automatic t_gc();
    logic [7:0] v;
    int r0;
    int l0;
    r0 = n_rr;
    l0 = n_ld;
    wr(8'he2, 8'h01);
    chk(8'(n_ld - l0), 8'h01);
    chk(8'(n_rr - r0), 8'h00);
    rd(8'he2, v);
    chk(v, 8'h00);
    wr(8'he2, 8'hc1);
    chk(8'(n_rr - r0), 8'h01);
    chk(8'(n_ld - l0), 8'h01);
    rd(8'he2, v);
    chk(v, 8'h00);
  endtask
  task automatic t_mode();
    logic ok;
    nrst_in <= 1'b0;
    mode <= 3'h1;
    h.cyc(6);
    nrst_in <= 1'b1;
    h.cyc(8);
    probe(7'h19, ok);
    chk({7'h00, ok}, 8'h00);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    h.cyc(6);
    nrst_in <= 1'b1;
    h.cyc(8);
    t_addr();
    $display("address test done");
    t_ident();
    $display("ident test done");
    t_gc();
    $display("control test done");
    t_mode();
    $display("mode test done");
    print_verdict();
  end
  // hang limit
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
endmodule // test_redriver_i2c_target_shared_regs
`default_nettype wire
